// >>> src/rsd_top.sv
// reset state distributor: classifies reset causes, keeps cause flags,
// drives default or retained values of core state, apb register slave
// assumes resetn is the power-on reset; other causes are async request pins and the software trigger register
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "rsd_cfg.svh"
module rsd_top (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic pin_rst_req,
    input wire logic lv_rst_req,
    input wire logic wdt_expire,
    input wire logic halt_mode,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic core_rst,
    output logic [5:0] cause_sel,
    output logic watchdog_timeout_flag,
    output logic power_down_flag,
    output logic low_voltage_cause_flag,
    output logic [7:0] port_a_latch,
    output logic [7:0] port_a_direction,
    output logic [7:0] reset_pin_select_reg,
    output logic [7:0] int_enable,
    output logic [3:0] timer_enable,
    output logic [2:0] stack_ptr,
    output logic [15:0] watchdog_counter
);
    // ============================================================
    // input synchronisation and event detection
    logic [4:0] sync_q;
    logic [2:0] req_prev_r;
    rsd_sync2 #(.W(5)) u_sync (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .d({halt_mode, wdt_expire, lv_rst_req, pin_rst_req, 1'b1}),
        .q(sync_q)
    );
    wire alive = sync_q[0];
    wire pin_ev = sync_q[1] & ~req_prev_r[0];
    wire lv_ev = sync_q[2] & ~req_prev_r[1];
    wire wdt_ev = sync_q[3] & ~req_prev_r[2];
    wire halted = sync_q[4];
    logic por_pend_r;
    // software-triggered reset: bit0 pin-type reset
    logic sw_rst_r;

    // ============================================================
    // cause selector, priority: power-on, low-voltage, pin, watchdog
    rsd_pkg::rsd_cause_t cause_r, cause_nxt;
    assign cause_nxt = por_pend_r ? rsd_pkg::RSD_CAUSE_POR :
                       lv_ev ? rsd_pkg::RSD_CAUSE_LVR :
                       (pin_ev | sw_rst_r) ? rsd_pkg::RSD_CAUSE_PIN :
                       (wdt_ev & halted) ? rsd_pkg::RSD_CAUSE_WDT_HALT :
                       wdt_ev ? rsd_pkg::RSD_CAUSE_WDT_RUN :
                       rsd_pkg::RSD_CAUSE_NONE;
    wire c_por = cause_r == rsd_pkg::RSD_CAUSE_POR;
    wire c_lvr = cause_r == rsd_pkg::RSD_CAUSE_LVR;
    wire c_wrun = cause_r == rsd_pkg::RSD_CAUSE_WDT_RUN;
    wire c_whalt = cause_r == rsd_pkg::RSD_CAUSE_WDT_HALT;
    wire c_cold = (cause_r != rsd_pkg::RSD_CAUSE_NONE) & ~c_whalt;
    wire c_any = cause_r != rsd_pkg::RSD_CAUSE_NONE;

    // ============================================================
    // apb decode
    wire acc = psel & penable;
    wire wr = acc & pwrite;
    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        hit = a == ofs;
    endfunction : hit
    wire wr_cause = wr & hit(paddr, `RSD_OFS_CAUSE);
    wire wr_trig = wr & hit(paddr, `RSD_OFS_TRIG);
    wire wr_st = wr & hit(paddr, `RSD_OFS_IRQ_ST);
    wire wr_msk = wr & hit(paddr, `RSD_OFS_IRQ_MSK);
    wire wr_port = wr & hit(paddr, `RSD_OFS_PORT);
    wire wr_ctrl = wr & hit(paddr, `RSD_OFS_CTRL);
    wire wr_psel = wr & hit(paddr, `RSD_OFS_PINSEL);
    wire mapped = hit(paddr, `RSD_OFS_CAUSE) | hit(paddr, `RSD_OFS_TRIG) | hit(paddr, `RSD_OFS_IRQ_ST) |
                  hit(paddr, `RSD_OFS_IRQ_MSK) | hit(paddr, `RSD_OFS_PORT) | hit(paddr, `RSD_OFS_CTRL) |
                  hit(paddr, `RSD_OFS_PINSEL);

    // ============================================================
    // cause flags
    logic to_nxt, pd_nxt, lv_nxt;
    assign to_nxt = c_por ? 1'b0 : (c_wrun | c_whalt) ? 1'b1 :
                    (wr_ctrl & pwdata[8]) ? 1'b0 : watchdog_timeout_flag;
    assign pd_nxt = c_por ? 1'b0 : c_whalt ? 1'b1 :
                    (wr_ctrl & pwdata[9]) ? 1'b1 : power_down_flag;
    // set wins over a software clear; software cannot set it
    assign lv_nxt = c_lvr ? 1'b1 : c_por ? 1'b0 :
                    (wr_cause & ~pwdata[`RSD_F_LVCAUSE]) ? 1'b0 : low_voltage_cause_flag;

    // ============================================================
    // distributed core state
    logic [7:0] pa_nxt, pac_nxt, psr_nxt, ien_nxt;
    logic [3:0] ten_nxt;
    logic [15:0] wdt_nxt;
    logic [2:0] sp_nxt;
    assign pa_nxt = c_cold ? `RSD_PORT_DEF : wr_port ? pwdata[7:0] : port_a_latch;
    assign pac_nxt = c_cold ? `RSD_PORT_DEF : wr_port ? pwdata[15:8] : port_a_direction;
    assign psr_nxt = c_cold ? `RSD_PINSEL_DEF : wr_psel ? pwdata[7:0] : reset_pin_select_reg;
    assign ien_nxt = c_cold ? `RSD_INT_EN_DEF : wr_ctrl ? pwdata[7:0] : int_enable;
    assign ten_nxt = c_cold ? `RSD_TMR_EN_DEF : wr_ctrl ? pwdata[19:16] : timer_enable;
    assign sp_nxt = c_any ? `RSD_SP_TOP : stack_ptr;
    assign wdt_nxt = c_any ? `RSD_WDT_DEF : (wr_ctrl & pwdata[24]) ? `RSD_WDT_DEF :
                     16'(watchdog_counter + 16'h0001);

    // ============================================================
    // core reset pulse, interrupts
    localparam logic [3:0] PULSE_CYC = 4'(`RSD_PULSE_CYC);
    logic [3:0] pulse_r;
    wire [3:0] pulse_nxt = c_any ? PULSE_CYC : (pulse_r != 4'h0) ? 4'(pulse_r - 4'h1) : 4'h0;
    logic [5:0] st_r, msk_r;
    wire [5:0] st_nxt = cause_r[5:0] & 6'h3e | (st_r & ~(wr_st ? pwdata[5:0] : 6'h00));

    // ============================================================
    // read mux
    wire [31:0] rd_cause = {29'h0, low_voltage_cause_flag, power_down_flag, watchdog_timeout_flag};
    wire [31:0] rd_val = hit(paddr, `RSD_OFS_CAUSE) ? rd_cause :
                         hit(paddr, `RSD_OFS_IRQ_ST) ? {26'h0, st_r} :
                         hit(paddr, `RSD_OFS_IRQ_MSK) ? {26'h0, msk_r} :
                         hit(paddr, `RSD_OFS_PORT) ? {16'h0, port_a_direction, port_a_latch} :
                         hit(paddr, `RSD_OFS_CTRL) ? {12'h0, timer_enable, 8'h0, int_enable} :
                         hit(paddr, `RSD_OFS_PINSEL) ? {24'h0, reset_pin_select_reg} :
                         hit(paddr, `RSD_OFS_TRIG) ? {26'h0, cause_sel} : 32'h0;

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            por_pend_r <= 1'b1;
            req_prev_r <= 3'h0;
            sw_rst_r <= 1'b0;
        end
        else
        begin
            por_pend_r <= ~alive;
            req_prev_r <= {sync_q[3], sync_q[2], sync_q[1]};
            sw_rst_r <= wr_trig & pwdata[0];
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cause_r <= rsd_pkg::RSD_CAUSE_NONE;
            cause_sel <= 6'h01;
            watchdog_timeout_flag <= 1'b0;
            power_down_flag <= 1'b0;
            low_voltage_cause_flag <= 1'b0;
        end
        else
        begin
            cause_r <= cause_nxt;
            cause_sel <= cause_r;
            watchdog_timeout_flag <= to_nxt;
            power_down_flag <= pd_nxt;
            low_voltage_cause_flag <= lv_nxt;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            port_a_latch <= `RSD_PORT_DEF;
            port_a_direction <= `RSD_PORT_DEF;
            reset_pin_select_reg <= `RSD_PINSEL_DEF;
            int_enable <= `RSD_INT_EN_DEF;
            timer_enable <= `RSD_TMR_EN_DEF;
            stack_ptr <= `RSD_SP_TOP;
            watchdog_counter <= `RSD_WDT_DEF;
        end
        else
        begin
            port_a_latch <= pa_nxt;
            port_a_direction <= pac_nxt;
            reset_pin_select_reg <= psr_nxt;
            int_enable <= ien_nxt;
            timer_enable <= ten_nxt;
            stack_ptr <= sp_nxt;
            watchdog_counter <= wdt_nxt;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pulse_r <= 4'h0;
            core_rst <= 1'b1;
            st_r <= 6'h00;
            msk_r <= 6'h00;
            irq <= 1'b0;
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pulse_r <= pulse_nxt;
            core_rst <= c_any | (pulse_r > 4'h1);
            st_r <= st_nxt;
            msk_r <= wr_msk ? pwdata[5:0] : msk_r;
            irq <= |(st_r & msk_r);
            prdata <= (psel & ~penable & ~pwrite) ? rd_val : prdata;
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
        end
    end

    // ============================================================
    // checks
    a_por_clears: assert property (@(posedge ref_clk) disable iff (!resetn)
        c_por |=> (!watchdog_timeout_flag && !power_down_flag && int_enable == 8'h00))
        else $error("power-on did not clear flags and enables");
    a_lvr_keeps: assert property (@(posedge ref_clk) disable iff (!resetn)
        c_lvr && !wr_ctrl |=> (watchdog_timeout_flag == $past(watchdog_timeout_flag)
        && power_down_flag == $past(power_down_flag)))
        else $error("low-voltage reset altered flags");
    a_wdt_run_sets: assert property (@(posedge ref_clk) disable iff (!resetn)
        c_wrun |=> watchdog_timeout_flag && power_down_flag == $past(power_down_flag))
        else $error("running watchdog reset flags wrong");
    a_wdt_halt_sets: assert property (@(posedge ref_clk) disable iff (!resetn)
        c_whalt |=> watchdog_timeout_flag && power_down_flag)
        else $error("halted watchdog reset flags wrong");
    a_timer_off: assert property (@(posedge ref_clk) disable iff (!resetn)
        c_por |=> timer_enable == 4'h0)
        else $error("timers still on after power-on");
    a_wdt_restart: assert property (@(posedge ref_clk) disable iff (!resetn)
        c_por ##1 !c_any && !wr_ctrl |=> watchdog_counter == 16'h0001)
        else $error("watchdog did not restart");
    a_port_inputs: assert property (@(posedge ref_clk) disable iff (!resetn)
        c_cold |=> port_a_latch == 8'hff && port_a_direction == 8'hff)
        else $error("ports not inputs after reset");
    a_warm_keeps: assert property (@(posedge ref_clk) disable iff (!resetn)
        c_whalt && !wr_psel |=> reset_pin_select_reg == $past(reset_pin_select_reg))
        else $error("warm reset changed pin select");
    a_lv_cause_set: assert property (@(posedge ref_clk) disable iff (!resetn)
        lv_ev && !por_pend_r |=> ##1 low_voltage_cause_flag)
        else $error("low-voltage cause flag not set");
    a_sp_top: assert property (@(posedge ref_clk) disable iff (!resetn)
        c_any |=> stack_ptr == 3'h0)
        else $error("stack pointer not at top");
endmodule : rsd_top

// >>> src/rsd_cfg.svh
// reset state distributor constants: offsets, fields, reset values, timing
// assumes inclusion by bare name from the top-level design module and the bench
`ifndef RSD_CFG_SVH
`define RSD_CFG_SVH
// ============================================================
// register offsets (byte addresses)
`define RSD_OFS_CAUSE 12'h000
`define RSD_OFS_TRIG 12'h004
`define RSD_OFS_IRQ_ST 12'h008
`define RSD_OFS_IRQ_MSK 12'h00c
`define RSD_OFS_PORT 12'h010
`define RSD_OFS_CTRL 12'h014
`define RSD_OFS_PINSEL 12'h018
// ============================================================
// cause register fields
`define RSD_F_TIMEOUT 0
`define RSD_F_PWRDN 1
`define RSD_F_LVCAUSE 2
// ============================================================
// default values
`define RSD_PORT_DEF 8'hff
`define RSD_PINSEL_DEF 8'h55
`define RSD_SP_TOP 3'h0
`define RSD_INT_EN_DEF 8'h00
`define RSD_TMR_EN_DEF 4'h0
`define RSD_WDT_DEF 16'h0000
// ============================================================
// timing: reset pulse held out to the core, in ns and cycles
`define RSD_CLK_NS 10
`define RSD_PULSE_NS 80
`define RSD_PULSE_CYC (`RSD_PULSE_NS / `RSD_CLK_NS)
`endif

// >>> src/rsd_pkg.sv
// reset state distributor types
// assumes the constants header is visible
package rsd_pkg;
    typedef enum logic [5:0] {
        RSD_CAUSE_NONE = 6'h01,
        RSD_CAUSE_POR = 6'h02,
        RSD_CAUSE_PIN = 6'h04,
        RSD_CAUSE_LVR = 6'h08,
        RSD_CAUSE_WDT_RUN = 6'h10,
        RSD_CAUSE_WDT_HALT = 6'h20
    } rsd_cause_t;
endpackage : rsd_pkg

// >>> src/rsd_sync2.sv
// two-flop synchroniser for a bus of asynchronous request lines
// assumes ref_clk domain and asynchronous active-low reset
`timescale 1ns/1ps
module rsd_sync2 #(
    parameter int W = 5
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_r <= '0;
            q <= '0;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : rsd_sync2

// >>> sim/rsd_top_tb.sv
// self-checking bench for the reset state distributor top level
// assumes rsd_cfg.svh on the include path and the design compiled before it
`timescale 1ns/1ps
`include "rsd_cfg.svh"
module rsd_top_tb;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic pin_rst_req = 1'b0;
    logic lv_rst_req = 1'b0;
    logic wdt_expire = 1'b0;
    logic halt_mode = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, irq, core_rst, tmo_f, pwd_f, lvc_f, err;
    logic [5:0] cause_sel;
    logic [7:0] pa_lat, pa_dir, pin_sel, int_en;
    logic [3:0] tmr_en;
    logic [2:0] sp;
    logic [15:0] wdog;
    logic [31:0] rd;
    int num_errors = 0;
    int checked = 0;

    always #5 ref_clk = ~ref_clk;

    rsd_top DUT (.ref_clk(ref_clk), .resetn(resetn), .pin_rst_req(pin_rst_req), .lv_rst_req(lv_rst_req),
        .wdt_expire(wdt_expire), .halt_mode(halt_mode), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .core_rst(core_rst), .cause_sel(cause_sel), .watchdog_timeout_flag(tmo_f), .power_down_flag(pwd_f),
        .low_voltage_cause_flag(lvc_f), .port_a_latch(pa_lat), .port_a_direction(pa_dir),
        .reset_pin_select_reg(pin_sel), .int_enable(int_en), .timer_enable(tmr_en), .stack_ptr(sp),
        .watchdog_counter(wdog));

    // ============================================================
    // reporting
    task complete_run;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run

    task stop(input string nm);
        $display("Error timeout waiting for %s", nm);
        num_errors++;
        complete_run();
    endtask : stop

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            $display("Error %s expected %h seen %h", nm, exp, got);
            num_errors++;
        end
    endtask : chk

    // ============================================================
    // bus and event drivers
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        for (n = 0; pready !== 1'b1 && n < 20; n++) @(posedge ref_clk);
        if (n >= 20) stop("pready");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // let the write land before callers look at outputs
        @(posedge ref_clk);
    endtask : apb

    // k: 0 pin, 1 low voltage, 2 watchdog, 3 software trigger
    task automatic fire(input int k, input logic [5:0] exp);
        int n;
        @(posedge ref_clk);
        pin_rst_req <= (k == 0);
        lv_rst_req <= (k == 1);
        wdt_expire <= (k == 2);
        if (k == 3) apb(1'b1, `RSD_OFS_TRIG, 32'h1);
        for (n = 0; cause_sel !== exp && n < 40; n++) @(posedge ref_clk);
        chk("cause_sel", {26'h0, exp}, {26'h0, cause_sel});
        if (n >= 40) stop("cause_sel");
        pin_rst_req <= 1'b0;
        lv_rst_req <= 1'b0;
        wdt_expire <= 1'b0;
        for (n = 0; core_rst !== 1'b1 && n < 40; n++) @(posedge ref_clk);
        if (n >= 40) stop("core_rst high");
        for (n = 0; core_rst !== 1'b0 && n < 40; n++) @(posedge ref_clk);
        if (n >= 40) stop("core_rst");
        repeat (3) @(posedge ref_clk);
    endtask : fire

    // ============================================================
    // scenarios
    task automatic t_por;
        logic [15:0] w;
        chk("timeout flag", 32'h0, tmo_f);
        chk("power down flag", 32'h0, pwd_f);
        chk("int_enable", 32'h0, int_en);
        chk("timer_enable", 32'h0, tmr_en);
        chk("port latch", 32'hff, pa_lat);
        chk("port direction", 32'hff, pa_dir);
        chk("stack_ptr", `RSD_SP_TOP, sp);
        chk("pin select", 32'h55, pin_sel);
        chk("core_rst", 32'h0, core_rst);
        w = wdog;
        repeat (5) @(posedge ref_clk);
        chk("watchdog count", w + 16'h5, wdog);
        $display("power-on test done");
    endtask : t_por

    task t_wdt_run;
        fire(2, 6'h10);
        chk("timeout flag", 32'h1, tmo_f);
        chk("power down flag", 32'h0, pwd_f);
        chk("port latch", 32'hff, pa_lat);
        $display("watchdog run test done");
    endtask : t_wdt_run

    task t_warm;
        apb(1'b1, `RSD_OFS_CTRL, 32'h0002_0133);
        chk("timeout flag", 32'h0, tmo_f);
        apb(1'b1, `RSD_OFS_PORT, 32'h0000_a5c3);
        apb(1'b1, `RSD_OFS_PINSEL, 32'h0000_00aa);
        halt_mode <= 1'b1;
        repeat (3) @(posedge ref_clk);
        fire(2, 6'h20);
        halt_mode <= 1'b0;
        chk("timeout flag", 32'h1, tmo_f);
        chk("power down flag", 32'h1, pwd_f);
        chk("port latch", 32'hc3, pa_lat);
        chk("port direction", 32'ha5, pa_dir);
        chk("pin select", 32'haa, pin_sel);
        chk("int_enable", 32'h33, int_en);
        chk("timer_enable", 32'h2, tmr_en);
        chk("stack_ptr", `RSD_SP_TOP, sp);
        $display("warm reset test done");
    endtask : t_warm

    task t_lvr;
        fire(1, 6'h08);
        chk("timeout flag", 32'h1, tmo_f);
        chk("power down flag", 32'h1, pwd_f);
        chk("lv cause flag", 32'h1, lvc_f);
        chk("port latch", 32'hff, pa_lat);
        chk("pin select", 32'h55, pin_sel);
        apb(1'b1, `RSD_OFS_CAUSE, 32'h3);
        chk("lv cause flag", 32'h0, lvc_f);
        apb(1'b1, `RSD_OFS_CAUSE, 32'h7);
        chk("lv cause flag", 32'h0, lvc_f);
        $display("low voltage test done");
    endtask : t_lvr

    task t_pin;
        apb(1'b1, `RSD_OFS_PORT, 32'h0000_1234);
        apb(1'b1, `RSD_OFS_PINSEL, 32'h0000_00aa);
        apb(1'b1, `RSD_OFS_CTRL, 32'h0003_005a);
        fire(0, 6'h04);
        chk("port latch", 32'hff, pa_lat);
        chk("port direction", 32'hff, pa_dir);
        chk("pin select", 32'h55, pin_sel);
        chk("int_enable", 32'h0, int_en);
        chk("timer_enable", 32'h0, tmr_en);
        chk("timeout flag", 32'h1, tmo_f);
        chk("power down flag", 32'h1, pwd_f);
        $display("pin reset test done");
    endtask : t_pin

    task t_irq;
        apb(1'b1, `RSD_OFS_IRQ_ST, 32'h3e);
        apb(1'b1, `RSD_OFS_IRQ_MSK, 32'h0);
        fire(3, 6'h04);
        apb(1'b0, `RSD_OFS_IRQ_ST, 32'h0);
        chk("irq status", 32'h4, rd);
        apb(1'b1, `RSD_OFS_IRQ_MSK, 32'h4);
        repeat (2) @(posedge ref_clk);
        chk("irq", 32'h1, irq);
        apb(1'b1, `RSD_OFS_IRQ_ST, 32'h4);
        repeat (2) @(posedge ref_clk);
        chk("irq", 32'h0, irq);
        apb(1'b0, `RSD_OFS_IRQ_ST, 32'h0);
        chk("irq status", 32'h0, rd);
        $display("interrupt test done");
    endtask : t_irq

    task t_bus;
        apb(1'b0, 12'h01c, 32'h0);
        chk("pslverr", 32'h1, err);
        chk("unmapped read", 32'h0, rd);
        apb(1'b1, 12'h01c, 32'hffff_ffff);
        chk("pslverr", 32'h1, err);
        $display("bus test done");
    endtask : t_bus

    initial
    begin
        repeat (6) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (16) @(posedge ref_clk);
        t_por();
        t_wdt_run();
        t_warm();
        t_lvr();
        t_pin();
        t_irq();
        t_bus();
        complete_run();
    end
endmodule : rsd_top_tb
